// ===== common/csf_cfg.svh
// Purpose: constants of the status flag register block
// Assumes: included by design files by bare name
// Notes:   definitions only
`ifndef CSF_CFG_SVH
`define CSF_CFG_SVH

// ----------------------------------------------------------------
// register map and bus
// ----------------------------------------------------------------
`define CSF_OFS_STATUS  8'h00   // byte address of the status register
`define CSF_BUS_W       32      // wishbone data width
`define CSF_REG_W       8       // status register width
`define CSF_RD_NONE     32'h0000_0000 // answer for an unmapped read

// ----------------------------------------------------------------
// bit positions of the status register
// ----------------------------------------------------------------
`define CSF_BIT_IRP     7   // indirect bank select
`define CSF_BIT_RPH     6   // direct bank select, high
`define CSF_BIT_RPL     5   // direct bank select, low
`define CSF_BIT_TO      4   // time-out flag, low true
`define CSF_BIT_PD      3   // power-down flag, low true
`define CSF_BIT_Z       2   // zero
`define CSF_BIT_DC      1   // digit carry / digit borrow
`define CSF_BIT_C       0   // carry / borrow

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CSF_RST_BANK    3'h0    // all three bank-select bits
`define CSF_RST_TOPD    1'h1    // time-out and power-down
`define CSF_RST_ALU     3'h0    // z, dc, c: undefined, held at zero

// ----------------------------------------------------------------
// arithmetic
// ----------------------------------------------------------------
`define CSF_NIB_CARRY   4       // carry position of a nibble sum
`define CSF_BYTE_CARRY  8       // carry position of a byte sum
`define CSF_SEL_LANE    0       // byte lane that holds the register

`endif

// ===== common/csf_pkg.sv
// Purpose: types of the status flag register block
// Assumes: csf_cfg.svh holds the numbers
// Notes:   the status layout follows the register bit order
package csf_pkg;

  // ----------------------------------------------------------------
  // instruction classes seen by the register
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CSF_OP_NONE   = 3'b000, // no flag effect, no write
    CSF_OP_ADD    = 3'b001, // add: z, dc, c
    CSF_OP_SUB    = 3'b010, // subtract: z, dc, c as borrow
    CSF_OP_LOGIC  = 3'b011, // logic result: z only
    CSF_OP_CLEAR  = 3'b100, // clear register: z set
    CSF_OP_MOVE   = 3'b101, // move, bit, swap: no flags
    CSF_OP_WDTCLR = 3'b110, // watchdog clear
    CSF_OP_SLEEP  = 3'b111  // sleep
  } csf_op_e;

  // the status register itself
  typedef struct packed {
    logic       indirect_bank_select;
    logic [1:0] direct_bank_select;
    logic       timeout_flag_n;
    logic       powerdown_flag_n;
    logic       zero_flag;
    logic       digit_carry_flag;
    logic       carry_flag;
  } csf_status_s;

  // flag results of one instruction
  typedef struct packed {
    logic [7:0] result;
    logic       zero;
    logic       digitCarry;
    logic       carry;
    logic       updZero;
    logic       updCarries;
  } csf_flags_s;

  // whole state of the top module
  typedef struct packed {
    csf_status_s status;
    logic        ack;
    logic [31:0] rdat;
  } csf_state_s;

endpackage

// ===== hw/csf_flag_calc.sv
// Purpose: result and zero/carry flags of one instruction
// Assumes: operands are stable while the instruction is offered
// Notes:   pure combinational, no state
`timescale 1ns/1ps
`include "csf_cfg.svh"
module csf_flag_calc
  import csf_pkg::*;
(
  input  wire csf_op_e    op,
  input  wire logic [7:0] opA,
  input  wire logic [7:0] opB,
  output csf_flags_s      flags
);

  // ----------------------------------------------------------------
  // adder shared by byte and nibble sums
  // ----------------------------------------------------------------
  function automatic logic [8:0] addc(input logic [7:0] x,
                                      input logic [7:0] y,
                                      input logic       cin);
    addc = {1'b0, x} + {1'b0, y} + {8'h00, cin};
  endfunction

  logic       isSub;  // subtract takes two's complement of opB
  logic [7:0] addend; // opB or its inverse
  logic [8:0] sumB;   // byte sum with carry
  logic [8:0] sumN;   // nibble sum with carry

  // subtraction adds the inverse plus one, so carry means no borrow
  always_comb begin
    isSub  = (op == CSF_OP_SUB);
    addend = isSub ? ~opB : opB;
    sumB   = addc(opA, addend, isSub);
    sumN   = addc({4'h0, opA[3:0]}, {4'h0, addend[3:0]}, isSub);
    flags  = '0;
    case (op)
      CSF_OP_ADD, CSF_OP_SUB: begin
        flags.result     = sumB[7:0];
        flags.carry      = sumB[`CSF_BYTE_CARRY];
        flags.digitCarry = sumN[`CSF_NIB_CARRY];
        flags.updCarries = 1'b1;
        flags.updZero    = 1'b1;
      end
      CSF_OP_LOGIC: begin
        flags.result  = opA;
        flags.updZero = 1'b1;
      end
      CSF_OP_CLEAR: begin
        flags.result  = 8'h00;
        flags.updZero = 1'b1;
      end
      CSF_OP_MOVE: begin
        flags.result = opA;
      end
      default: begin
        flags.result = 8'h00;
      end
    endcase
    flags.zero = (flags.result == 8'h00);
  end

endmodule

// ===== hw/csf_bank_decode.sv
// Purpose: data-memory address from the bank select bits
// Assumes: bank bits come straight from the status register
// Notes:   combinational, so a bank change acts on the next access
`timescale 1ns/1ps
module csf_bank_decode
  import csf_pkg::*;
(
  input  wire logic [1:0] directBank,
  input  wire logic       indirectBank,
  input  wire logic [6:0] directAddr,
  input  wire logic [7:0] indirectPtr,
  output logic      [8:0] directFull,
  output logic      [8:0] indirectFull
);

  // ----------------------------------------------------------------
  // bank bits extend the short addresses to nine bits
  // ----------------------------------------------------------------
  // 00 -> 000h-07Fh ... 11 -> 180h-1FFh
  assign directFull   = {directBank, directAddr};
  // 0 -> 000h-0FFh, 1 -> 100h-1FFh
  assign indirectFull = {indirectBank, indirectPtr};

endmodule

// ===== hw/csf_status_reg.sv
// Purpose: processor status register with alu flags and bank select
// Assumes: execution unit and watchdog run on core_clk
// Notes:   wishbone slave and instruction port share one register
//
// Implementation choices: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
`include "csf_cfg.svh"
module csf_status_reg
  import csf_pkg::*;
#(
  parameter int ADDR_W = 8 // wishbone byte address width
)
(
  input  wire logic              core_clk,
  input  wire logic              resetn,
  // wishbone classic slave
  input  wire logic              wbCyc,
  input  wire logic              wbStb,
  input  wire logic              wbWe,
  input  wire logic [ADDR_W-1:0] wbAdr,
  input  wire logic [3:0]        wbSel,
  input  wire logic [31:0]       wbDatW,
  output logic      [31:0]       wbDatR,
  output logic                   wbAck,
  // instruction port from the execution unit
  input  wire logic              exValid,
  output logic                   exReady,
  input  wire csf_op_e           exOp,
  input  wire logic              exDestStatus,
  input  wire logic [7:0]        exOpA,
  input  wire logic [7:0]        exOpB,
  output logic      [7:0]        exResult,
  // watchdog event
  input  wire logic              wdtTimeout,
  // register value and bank addressing
  output logic      [7:0]        statusOut,
  input  wire logic [6:0]        directAddr,
  input  wire logic [7:0]        indirectPtr,
  output logic      [8:0]        directFull,
  output logic      [8:0]        indirectFull
);

  // ----------------------------------------------------------------
  // state and helpers
  // ----------------------------------------------------------------
  csf_state_s  stQ;       // registered state
  csf_state_s  stD;       // next state
  csf_flags_s  flg;       // flags of the offered instruction
  csf_status_s wrVal;     // value presented by a write
  logic        hitStatus; // bus address decodes to the register
  logic        busReq;    // new bus request, not yet answered
  logic        busWr;     // bus write takes effect this edge
  logic        exFire;    // instruction executes this edge
  logic [7:0]  wrByte;    // raw byte written

  // ----------------------------------------------------------------
  // flag calculation
  // ----------------------------------------------------------------
  csf_flag_calc u_flags (
    .op    (exOp),
    .opA   (exOpA),
    .opB   (exOpB),
    .flags (flg)
  );

  // ----------------------------------------------------------------
  // bank decode
  // ----------------------------------------------------------------
  csf_bank_decode u_bank (
    .directBank   (stQ.status.direct_bank_select),
    .indirectBank (stQ.status.indirect_bank_select),
    .directAddr   (directAddr),
    .indirectPtr  (indirectPtr),
    .directFull   (directFull),
    .indirectFull (indirectFull)
  );

  // ----------------------------------------------------------------
  // handshakes
  // ----------------------------------------------------------------
  // the write lands at the edge where the master sees ack
  assign hitStatus = (wbAdr == ADDR_W'(`CSF_OFS_STATUS));
  assign busReq    = wbCyc && wbStb && !stQ.ack;
  assign busWr     = wbCyc && wbStb && wbWe && stQ.ack && hitStatus
                     && wbSel[`CSF_SEL_LANE];
  // a landing bus write stalls the instruction for one cycle,
  // so neither update is lost
  assign exReady   = !busWr;
  assign exFire    = exValid && exReady;
  assign wbAck     = stQ.ack;
  assign wbDatR    = stQ.rdat;
  assign statusOut = stQ.status;
  assign exResult  = flg.result;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    stD    = stQ;
    wrVal  = stQ.status;
    wrByte = 8'h00;
    // bus answer: one cycle of ack, read data sampled with it
    stD.ack = busReq;
    if (busReq) begin
      stD.rdat = hitStatus ? {24'h0, stQ.status} : `CSF_RD_NONE;
    end
    // pick the written byte: bus or instruction destination
    if (busWr) begin
      wrByte = wbDatW[7:0];
    end else if (exFire && exDestStatus) begin
      wrByte = flg.result;
    end
    if (busWr || (exFire && exDestStatus &&
                  exOp != CSF_OP_WDTCLR && exOp != CSF_OP_SLEEP &&
                  exOp != CSF_OP_NONE)) begin
      wrVal.indirect_bank_select = wrByte[`CSF_BIT_IRP];
      wrVal.direct_bank_select   =
        wrByte[`CSF_BIT_RPH:`CSF_BIT_RPL];
      // time-out and power-down keep their value on any write
      if (busWr || !(flg.updZero || flg.updCarries)) begin
        wrVal.zero_flag        = wrByte[`CSF_BIT_Z];
        wrVal.digit_carry_flag = wrByte[`CSF_BIT_DC];
        wrVal.carry_flag       = wrByte[`CSF_BIT_C];
      end
      // flag-updating instructions drop the written z, dc, c
      // (bits they do not update stay as they were)
      else begin
        wrVal.zero_flag        = stQ.status.zero_flag;
        wrVal.digit_carry_flag = stQ.status.digit_carry_flag;
        wrVal.carry_flag       = stQ.status.carry_flag;
      end
    end
    // flag logic wins over any written flag value
    if (exFire && flg.updZero) begin
      wrVal.zero_flag = flg.zero;
    end
    if (exFire && flg.updCarries) begin
      wrVal.digit_carry_flag = flg.digitCarry;
      wrVal.carry_flag       = flg.carry;
    end
    // reset-cause flags move only on watchdog clear, sleep and watchdog expiry
    if (exFire && exOp == CSF_OP_WDTCLR) begin
      wrVal.timeout_flag_n   = 1'b1;
      wrVal.powerdown_flag_n = 1'b1;
    end
    if (exFire && exOp == CSF_OP_SLEEP) begin
      wrVal.timeout_flag_n   = 1'b1;
      wrVal.powerdown_flag_n = 1'b0;
    end
    // a watchdog expiry in the same cycle wins over clear/sleep
    if (wdtTimeout) begin
      wrVal.timeout_flag_n = 1'b0;
    end
    stD.status = wrVal;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // z, dc and c are undefined at power-on; zero keeps sims clean
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      stQ <= '0;
      {stQ.status.indirect_bank_select,
       stQ.status.direct_bank_select} <= `CSF_RST_BANK;
      stQ.status.timeout_flag_n   <= `CSF_RST_TOPD;
      stQ.status.powerdown_flag_n <= `CSF_RST_TOPD;
      {stQ.status.zero_flag, stQ.status.digit_carry_flag,
       stQ.status.carry_flag} <= `CSF_RST_ALU;
    end else begin
      stQ <= stD;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  // helper: instruction classes
  logic fireAdd;  // add executes
  logic fireSub;  // subtract executes
  logic fireClr;  // clear aimed at the register
  assign fireAdd = exFire && exOp == CSF_OP_ADD && !exDestStatus;
  assign fireSub = exFire && exOp == CSF_OP_SUB && !exDestStatus;
  assign fireClr = exFire && exOp == CSF_OP_CLEAR && exDestStatus;

  // a bus request followed by its answer
  sequence sBusWrite;
    wbCyc && wbStb && wbWe && hitStatus && wbSel[`CSF_SEL_LANE] && !wbAck
    ##1 wbAck && !exValid && !wdtTimeout;
  endsequence

  // a sleep followed by one quiet cycle
  sequence sSleepQuiet;
    exFire && exOp == CSF_OP_SLEEP && !wdtTimeout
    ##1 !exFire && !wdtTimeout;
  endsequence

  a_ack_one_cycle:
    assert property (wbAck |=> !wbAck)
    else $error("ack held more than one cycle");

  a_ack_latency:
    assert property (busReq |=> wbAck)
    else $error("no ack one cycle after request");

  a_bus_write_lands:
    assert property (sBusWrite |=> statusOut[7:5] == $past(wbDatW[7:5])
                     && statusOut[2:0] == $past(wbDatW[2:0]))
    else $error("bus write did not land");

  a_topd_no_write:
    assert property (busWr && !exFire && !wdtTimeout |=>
                     $stable(statusOut[4:3]))
    else $error("time-out or power-down changed by write");

  a_clear_pattern:
    assert property (fireClr && !wdtTimeout |=>
                     statusOut[7:5] == 3'h0 && statusOut[2] &&
                     $stable(statusOut[4:3]) && $stable(statusOut[1:0]))
    else $error("clear did not give 000u uluu");

  a_sub_borrow:
    assert property (fireSub |=>
                     statusOut[0] == ($past(exOpA) >= $past(exOpB)))
    else $error("subtract carry is not inverted borrow");

  a_add_carry:
    assert property (fireAdd |=> statusOut[0] ==
      (9'($past(exOpA)) + 9'($past(exOpB)) > 9'h0ff))
    else $error("add carry wrong");

  a_add_dcarry:
    assert property (fireAdd |=> statusOut[1] ==
      (5'($past(exOpA[3:0])) + 5'($past(exOpB[3:0])) > 5'h0f))
    else $error("add digit carry wrong");

  // expected zero comes from the operands, not from the result port
  a_zero_flag:
    assert property (fireAdd |=> statusOut[2] ==
      (8'($past(exOpA) + $past(exOpB)) == 8'h00))
    else $error("zero flag wrong");

  // an add aimed at the register: bit 0 of the result must not land
  a_dest_flag_wins:
    assert property (exFire && exDestStatus && exOp == CSF_OP_ADD |=>
      statusOut[0] == (9'($past(exOpA)) + 9'($past(exOpB)) > 9'h0ff))
    else $error("written carry not replaced by flag logic");

  // a move into the register leaves the reset-cause bits alone
  a_topd_no_move:
    assert property (exFire && exDestStatus && exOp == CSF_OP_MOVE &&
                     !wdtTimeout |=> $stable(statusOut[4:3]))
    else $error("time-out or power-down changed by move");

  // reset value is checked during reset itself, so no disable here
  a_reset_value:
    assert property (@(posedge core_clk) disable iff (1'b0)
                     !resetn |=> statusOut == {`CSF_RST_BANK,
                     `CSF_RST_TOPD, `CSF_RST_TOPD, `CSF_RST_ALU})
    else $error("reset value of the register wrong");

  a_sleep_flags:
    assert property (sSleepQuiet |-> statusOut[4:3] == 2'b10
                     ##1 statusOut[4:3] == 2'b10)
    else $error("sleep did not give time-out 1, power-down 0");

  a_wdt_timeout:
    assert property (wdtTimeout |=> !statusOut[4])
    else $error("watchdog expiry did not clear time-out");

  a_bank_decode:
    assert property (directFull[8:7] == statusOut[6:5] &&
                     indirectFull[8] == statusOut[7])
    else $error("bank select not applied to address");

endmodule

// ===== sim/csf_exec_model.sv
// Purpose: execution unit stand-in that offers instructions
// Assumes: same clock as the register; ready is read at a rising edge
// Notes:   operands are scrambled once an instruction is taken
`timescale 1ns/1ps
module csf_exec_model
  import csf_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       exReady,
  input  wire logic [7:0] exResult,
  output logic            exValid,
  output csf_op_e         exOp,
  output logic            exDestStatus,
  output logic [7:0]      exOpA,
  output logic [7:0]      exOpB,
  output logic            wdtTimeout
);
  // ------------------------------------------------------------
  // idle levels and offer tasks
  // ------------------------------------------------------------
  initial begin
    exValid      = 1'b0;
    exOp         = CSF_OP_NONE;
    exDestStatus = 1'b0;
    exOpA        = 8'h00;
    exOpB        = 8'h00;
    wdtTimeout   = 1'b0;
  end

  // offer held until ready is seen at a rising edge; taken at that edge
  task automatic issue(input csf_op_e op, input logic dest,
                       input logic [7:0] a, input logic [7:0] b,
                       output logic ok, output logic [7:0] res);
    int n;
    n   = 0;
    ok  = 1'b0;
    res = 8'h00;
    @(posedge core_clk);
    exValid      <= 1'b1;
    exOp         <= op;
    exDestStatus <= dest;
    exOpA        <= a;
    exOpB        <= b;
    while (!ok && n < 20) begin
      @(posedge core_clk);
      ok  = (exReady === 1'b1);
      res = exResult;
      n++;
    end
    // inverted so that a late look at stale operands shows up
    exValid      <= 1'b0;
    exOp         <= CSF_OP_NONE;
    exDestStatus <= ~dest;
    exOpA        <= ~a;
    exOpB        <= ~b;
  endtask

  // one-cycle watchdog time-out pulse
  task automatic pulseWdt();
    @(posedge core_clk);
    wdtTimeout <= 1'b1;
    @(posedge core_clk);
    wdtTimeout <= 1'b0;
  endtask
endmodule

// ===== sim/tb_top.sv
// Purpose: self-checking bench of the status flag register
// Assumes: one clock, register at offset 8'h00, one-cycle ack
// Notes:   expected values are worked out by hand from the flag rules
`timescale 1ns/1ps
module tb_top
  import csf_pkg::*;
;
  logic        core_clk    = 1'b0;
  logic        resetn      = 1'b0;
  logic        wbCyc       = 1'b0;
  logic        wbStb       = 1'b0;
  logic        wbWe        = 1'b0;
  logic [7:0]  wbAdr       = 8'h00;
  logic [3:0]  wbSel       = 4'h0;
  logic [31:0] wbDatW      = 32'h0;
  logic [6:0]  directAddr  = 7'h05;
  logic [7:0]  indirectPtr = 8'h10;
  logic [31:0] wbDatR;
  logic        wbAck;
  logic        exValid;
  logic        exReady;
  logic        exDestStatus;
  logic        wdtTimeout;
  csf_op_e     exOp;
  logic [7:0]  exOpA;
  logic [7:0]  exOpB;
  logic [7:0]  exResult;
  logic [7:0]  statusOut;
  logic [8:0]  directFull;
  logic [8:0]  indirectFull;
  logic        ok;
  logic [7:0]  res;
  logic [31:0] q;
  int          n_mismatch  = 0;
  int          num_checks  = 0;

  // 100 MHz clock
  always #5 core_clk = ~core_clk;

  // ------------------------------------------------------------
  // design and execution unit model
  // ------------------------------------------------------------
  csf_status_reg #(.ADDR_W(8)) i_dut (
    .core_clk(core_clk), .resetn(resetn), .wbCyc(wbCyc),
    .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel),
    .wbDatW(wbDatW), .wbDatR(wbDatR), .wbAck(wbAck),
    .exValid(exValid), .exReady(exReady), .exOp(exOp),
    .exDestStatus(exDestStatus), .exOpA(exOpA), .exOpB(exOpB),
    .exResult(exResult), .wdtTimeout(wdtTimeout),
    .statusOut(statusOut), .directAddr(directAddr),
    .indirectPtr(indirectPtr), .directFull(directFull),
    .indirectFull(indirectFull)
  );

  csf_exec_model i_exec (
    .core_clk(core_clk), .exReady(exReady), .exResult(exResult),
    .exValid(exValid), .exOp(exOp), .exDestStatus(exDestStatus),
    .exOpA(exOpA), .exOpB(exOpB), .wdtTimeout(wdtTimeout)
  );

  // ------------------------------------------------------------
  // report, compare and access tasks
  // ------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d, mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // four-state compare, so an unknown never matches
  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s: expected %h, seen %h", what, e, g);
    end
  endtask

  // a wait that ran out ends the run at once
  task automatic hang(input string what);
    n_mismatch++;
    $display("wrong value %s: expected answer, seen none", what);
    end_sim();
  endtask

  // classic single cycle; ack, data and ready taken at a rising edge,
  // and the request released by that same edge
  task automatic wbx(input logic we, input logic [7:0] adr,
                     input logic [31:0] d);
    int n;
    logic ak;
    logic rdy;
    n   = 0;
    ak  = 1'b0;
    rdy = 1'b1;
    @(posedge core_clk);
    wbCyc  <= 1'b1;
    wbStb  <= 1'b1;
    wbWe   <= we;
    wbAdr  <= adr;
    wbSel  <= 4'h1;
    wbDatW <= d;
    while (!ak && n < 20) begin
      @(posedge core_clk);
      ak  = (wbAck === 1'b1);
      q   = wbDatR;
      rdy = exReady;
      n++;
    end
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe  <= 1'b0;
    if (!ak) hang("bus ack");
    // a landing write to the register stalls the instruction port
    chk("ready", {31'h0, !(we && adr == 8'h00)}, {31'h0, rdy});
    @(negedge core_clk);
    chk("ack drop", 32'h0, {31'h0, wbAck});
  endtask

  task automatic rd(input logic [7:0] adr, input logic [31:0] e);
    wbx(1'b0, adr, 32'h0);
    chk("read data", e, q);
  endtask

  // offer one instruction, then look at result and register
  task automatic ex(input csf_op_e op, input logic dest,
                    input logic [7:0] a, input logic [7:0] b,
                    input logic cr, input logic [7:0] er,
                    input logic [7:0] es);
    i_exec.issue(op, dest, a, b, ok, res);
    if (!ok) hang("instruction ready");
    @(negedge core_clk);
    if (cr) chk("result", {24'h0, er}, {24'h0, res});
    chk("status", {24'h0, es}, {24'h0, statusOut});
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (6) @(posedge core_clk);
    resetn <= 1'b1;
    @(negedge core_clk);
    chk("status", 32'h18, {24'h0, statusOut});
    rd(8'h00, 32'h18);
    $display("test reset done");
    // time-out and power-down refuse bus writes
    wbx(1'b1, 8'h00, 32'he7);
    chk("status", 32'hff, {24'h0, statusOut});
    rd(8'h00, 32'hff);
    // every bank code, indirect bit following the low code bit
    for (int i = 0; i < 4; i++) begin
      wbx(1'b1, 8'h00, {24'h0, i[0], i[1:0], 5'h00});
      chk("direct", {23'h0, i[1:0], 7'h05}, {23'h0, directFull});
      chk("indirect", {23'h0, i[0], 8'h10}, {23'h0, indirectFull});
    end
    chk("status", 32'hf8, {24'h0, statusOut});
    $display("test bus and banks done");
    // carries, zero and borrow sense
    ex(CSF_OP_ADD, 1'b0, 8'h0f, 8'h01, 1'b1, 8'h10, 8'hfa);
    ex(CSF_OP_ADD, 1'b0, 8'hff, 8'h01, 1'b1, 8'h00, 8'hff);
    ex(CSF_OP_SUB, 1'b0, 8'h05, 8'h03, 1'b1, 8'h02, 8'hfb);
    ex(CSF_OP_SUB, 1'b0, 8'h03, 8'h05, 1'b1, 8'hfe, 8'hf8);
    $display("test flags done");
    // register as destination: flag ops take the flags they update from flag logic, move from the byte, none no write
    ex(CSF_OP_LOGIC, 1'b1, 8'h00, 8'h00, 1'b1, 8'h00, 8'h1c);
    ex(CSF_OP_ADD, 1'b1, 8'h7f, 8'h80, 1'b1, 8'hff, 8'hf8);
    ex(CSF_OP_MOVE, 1'b1, 8'ha5, 8'h00, 1'b1, 8'ha5, 8'hbd);
    ex(CSF_OP_NONE, 1'b1, 8'hff, 8'h00, 1'b0, 8'h00, 8'hbd);
    ex(CSF_OP_CLEAR, 1'b1, 8'h5a, 8'h00, 1'b0, 8'h00, 8'h1d);
    $display("test destination done");
    // reset-cause flags from sleep, watchdog and watchdog clear
    ex(CSF_OP_SLEEP, 1'b0, 8'h00, 8'h00, 1'b0, 8'h00, 8'h15);
    i_exec.pulseWdt();
    @(negedge core_clk);
    chk("status", 32'h05, {24'h0, statusOut});
    ex(CSF_OP_WDTCLR, 1'b0, 8'h00, 8'h00, 1'b0, 8'h00, 8'h1d);
    wbx(1'b1, 8'h00, 32'h0);
    chk("status", 32'h18, {24'h0, statusOut});
    $display("test reset cause done");
    // unmapped place: write ignored, read gives zero
    wbx(1'b1, 8'h04, 32'hff);
    chk("status", 32'h18, {24'h0, statusOut});
    rd(8'h04, 32'h0);
    $display("test unmapped done");
    // instruction offered while a bus write lands: stalled, both kept
    fork
      wbx(1'b1, 8'h00, 32'ha0);
      begin
        @(posedge core_clk);
        ex(CSF_OP_ADD, 1'b0, 8'hff, 8'h01, 1'b1, 8'h00, 8'hbf);
      end
    join
    $display("test stall done");
    end_sim();
  end
endmodule
